// *** include/cal_regs_pkg.sv ***
// Constants shared by the calibration, reset and presence register bank.
// Assumes a 40 MHz system clock and 32-bit AHB-Lite data with word-aligned registers.
package cal_regs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  ADC_CAL_IDX     = 8'h19;
  localparam logic [7:0]  DAC_CAL_IDX     = 8'h1a;
  localparam logic [7:0]  RESET_IDX       = 8'h1b;
  localparam logic [7:0]  UNUSED_LO_IDX   = 8'h1c;
  localparam logic [7:0]  UNUSED_HI_IDX   = 8'h1e;
  localparam logic [7:0]  PRESENCE_IDX    = 8'h1f;
  localparam logic [7:0]  STATUS_IDX      = 8'h20;
  localparam logic [7:0]  WIPER_IDX       = 8'h21;

  // Calibration port fields
  localparam int          CAL_DATA_BIT    = 7;
  localparam int          CAL_CLK_BIT     = 0;
  localparam logic [7:0]  CAL_PORT_RESET  = 8'h00;

  // Subsystem_reset_pulse fields
  localparam int          CLR_QUEUE_BIT   = 0;
  localparam int          CLR_POT_BIT     = 1;
  localparam int          CLR_PARALLEL_BIT = 2;
  localparam int          CLR_DAC_BIT     = 3;
  localparam int          CLR_GLOBAL_BIT  = 4;
  localparam int          CLR_BITS        = 5;

  // Presence register value: only bit 0 set
  localparam logic [31:0] PRESENCE_VALUE  = 32'h0000_0001;

  // Status register fields
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_GAP_OK_BIT = 1;

  // Potentiometer serial frame
  localparam int          POT_ADDR_BITS   = 2;
  localparam int          POT_DATA_BITS   = 8;
  localparam logic [3:0]  POT_FRAME_BITS  = 4'ha;
  localparam logic [1:0]  POT_ADDR_FIRST  = 2'h0;
  localparam logic [1:0]  POT_ADDR_SECOND = 2'h1;
  localparam logic [7:0]  WIPER_RESET     = 8'h80;

  // Timing
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          GAP_TIME_NS     = 4000;
  localparam int          GAP_CYCLES      = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BUSY_TIME_MS    = 20;
  localparam int          BUSY_CYCLES     = (BUSY_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int          GAP_CNT_W       = 8;
  localparam int          BUSY_CNT_W      = 20;

  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

endpackage : cal_regs_pkg

// *** core/hold_timer.sv ***
// Retriggerable hold timer: active for a fixed number of cycles after a start pulse.
// Assumes start comes from logic on the same clock.
`timescale 1ns/10ps
module hold_timer #(
  parameter int W     = 8,
  parameter int COUNT = 16
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      active,
  output logic      idle
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         active;
    logic         idle;
  } timer_s;

  timer_s st_r;
  timer_s st_nxt;

  // Restart wins over expiry so a late access always extends the window
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt    = W'(COUNT - 1);
      st_nxt.active = 1'b1;
      st_nxt.idle   = 1'b0;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - W'(1);
    end else begin
      st_nxt.active = 1'b0;
      st_nxt.idle   = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{cnt: '0, active: 1'b0, idle: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.active;
  assign idle   = st_r.idle;

endmodule : hold_timer

// *** core/pot_serial_model.sv ***
// Pair of 8-bit calibration potentiometers loaded by a bit-banged serial frame.
// Assumes one wr strobe per host write to the port, with data and clock levels alongside.
`timescale 1ns/10ps
module pot_serial_model
  import cal_regs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic       sdata,
  input  wire logic       sclk,
  input  wire logic       clr,
  output logic [7:0]      wiper0,
  output logic [7:0]      wiper1
);

  typedef struct packed {
    logic       active;
    logic [3:0] cnt;
    logic [9:0] shreg;
    logic [7:0] wiper0;
    logic [7:0] wiper1;
  } pot_s;

  pot_s st_r;
  pot_s st_nxt;

  // Frame decode: enable, clocked bits, then an end write latches the wiper
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.active = 1'b0;
      st_nxt.cnt    = '0;
      st_nxt.shreg  = '0;
      st_nxt.wiper0 = WIPER_RESET;
      st_nxt.wiper1 = WIPER_RESET;
    end else if (wr) begin
      if (sclk) begin
        // Address then data, MSB first; extra bits spoil the frame
        if (st_r.active && st_r.cnt != 4'hf) begin
          st_nxt.shreg = {st_r.shreg[8:0], sdata};
          st_nxt.cnt   = st_r.cnt + 4'h1;
        end
      end else if (sdata) begin
        st_nxt.active = 1'b1;
        st_nxt.cnt    = '0;
      end else begin
        // Only a complete frame loads; short or long ones are dropped
        if (st_r.active && st_r.cnt == POT_FRAME_BITS) begin
          if (st_r.shreg[9:8] == POT_ADDR_FIRST) begin
            st_nxt.wiper0 = st_r.shreg[7:0];
          end else if (st_r.shreg[9:8] == POT_ADDR_SECOND) begin
            st_nxt.wiper1 = st_r.shreg[7:0];
          end
        end
        st_nxt.active = 1'b0;
        st_nxt.cnt    = '0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{active: 1'b0, cnt: '0, shreg: '0, wiper0: WIPER_RESET, wiper1: WIPER_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wiper0 = st_r.wiper0;
  assign wiper1 = st_r.wiper1;

endmodule : pot_serial_model

// *** core/cal_reset_regs.sv ***
// Calibration serial ports, subsystem reset pulses and board presence behind AHB-Lite.
// Assumes a single AHB-Lite master on ref_clk and same-clock memory access strobes.
//
// Functional notes
// - Memory is unavailable for 20 ms after its terminating write.
// - A/D calibration port is write-only: bit 7 data, bit 0 clock.
// - Pot address 00 picks offset (or first DAC), 01 picks gain.
// - Each pot holds an 8-bit wiper value loaded serially.
// - Address bits go most significant first.
// - Data bits go D7 down to D0 right after the address.
// - DAC calibration port has the same format; 00 DAC0, 01 DAC1 gain.
// - DAC path has gain pots only, no offset pot.
// - Reset bit 0 clears the A/D data queue.
// - Reset bit 1 resets the calibration pots.
// - Reset bit 2 resets parallel ports A and B.
// - Reset bit 3 returns both DAC outputs to zero.
// - Reset bit 4 does all four resets plus configuration defaults.
// - Offsets 1C to 1E have no register behind them.
// - Presence register reads 01: card detected, upper bits zero.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module cal_reset_regs
  import cal_regs_pkg::*;
#(
  parameter int BUSY_CNT = BUSY_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             adc_cal_sclk,
  output logic             adc_cal_sdata,
  output logic             dac_cal_sclk,
  output logic             dac_cal_sdata,
  output logic             adc_queue_clear,
  output logic             cal_pot_clear,
  output logic             parallel_port_clear,
  output logic             analog_out_zero,
  output logic             global_clear,
  output logic [7:0]       adc_offset_wiper,
  output logic [7:0]       adc_gain_wiper,
  output logic [7:0]       dac0_gain_wiper,
  output logic [7:0]       dac1_gain_wiper,
  input  wire logic        nvm_access,
  input  wire logic        nvm_end_write,
  output logic             nvm_busy,
  output logic             nvm_gap_ok
);

  typedef struct packed {
    logic                wr_pend;
    logic [7:0]          wr_idx;
    logic [31:0]         rdata;
    logic                ready;
    logic [7:0]          adc_port;
    logic [7:0]          dac_port;
    logic                adc_wr;
    logic                dac_wr;
    logic [CLR_BITS-1:0] clr;
  } regs_s;

  regs_s       st_r;
  regs_s       st_nxt;
  logic        addr_phase;
  logic        addr_ok;
  logic [7:0]  addr_idx;
  logic        pot_clr;
  logic        busy_w;
  logic        gap_w;

  // Address phase qualifier; haddr bits above the index must be zero to hit
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_idx   = haddr[9:2];
  assign addr_ok    = (haddr[31:10] == '0) && (haddr[1:0] == 2'h0);

  // Bus slave, calibration ports and reset pulses
  always_comb begin
    st_nxt        = st_r;
    st_nxt.ready  = 1'b1;
    st_nxt.adc_wr = 1'b0;
    st_nxt.dac_wr = 1'b0;
    st_nxt.clr    = '0;
    st_nxt.rdata  = '0;

    // Data phase of a captured write
    if (st_r.wr_pend) begin
      st_nxt.wr_pend = 1'b0;
      case (st_r.wr_idx)
        ADC_CAL_IDX: begin
          st_nxt.adc_port = hwdata[7:0];
          st_nxt.adc_wr   = 1'b1;
        end
        DAC_CAL_IDX: begin
          st_nxt.dac_port = hwdata[7:0];
          st_nxt.dac_wr   = 1'b1;
        end
        RESET_IDX: begin
          // Global clear fans out to every individual clear
          st_nxt.clr[CLR_QUEUE_BIT]    = hwdata[CLR_QUEUE_BIT] | hwdata[CLR_GLOBAL_BIT];
          st_nxt.clr[CLR_POT_BIT]      = hwdata[CLR_POT_BIT] | hwdata[CLR_GLOBAL_BIT];
          st_nxt.clr[CLR_PARALLEL_BIT] = hwdata[CLR_PARALLEL_BIT] | hwdata[CLR_GLOBAL_BIT];
          st_nxt.clr[CLR_DAC_BIT]      = hwdata[CLR_DAC_BIT] | hwdata[CLR_GLOBAL_BIT];
          st_nxt.clr[CLR_GLOBAL_BIT]   = hwdata[CLR_GLOBAL_BIT];
          if (hwdata[CLR_GLOBAL_BIT]) begin
            st_nxt.adc_port = CAL_PORT_RESET;
            st_nxt.dac_port = CAL_PORT_RESET;
          end
        end
        default: begin
          // Unused offsets and read-only registers swallow writes
        end
      endcase
    end

    // Address phase: writes are deferred, reads answer with zero wait
    if (addr_phase) begin
      if (hwrite) begin
        st_nxt.wr_pend = addr_ok;
        st_nxt.wr_idx  = addr_idx;
      end else if (addr_ok) begin
        case (addr_idx)
          PRESENCE_IDX: st_nxt.rdata = PRESENCE_VALUE;
          STATUS_IDX: begin
            st_nxt.rdata[STAT_BUSY_BIT]   = busy_w;
            st_nxt.rdata[STAT_GAP_OK_BIT] = gap_w;
          end
          WIPER_IDX: begin
            st_nxt.rdata = {dac1_gain_wiper, dac0_gain_wiper, adc_gain_wiper, adc_offset_wiper};
          end
          // Write-only ports and unused offsets read as zero
          default: st_nxt.rdata = '0;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{wr_pend: 1'b0, wr_idx: '0, rdata: '0, ready: 1'b1,
                adc_port: CAL_PORT_RESET, dac_port: CAL_PORT_RESET,
                adc_wr: 1'b0, dac_wr: 1'b0, clr: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pot_clr = st_r.clr[CLR_POT_BIT];

  // A/D pots: offset at address 0, gain at address 1
  pot_serial_model u_adc_pots (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr      (st_r.adc_wr),
    .sdata   (st_r.adc_port[CAL_DATA_BIT]),
    .sclk    (st_r.adc_port[CAL_CLK_BIT]),
    .clr     (pot_clr),
    .wiper0  (adc_offset_wiper),
    .wiper1  (adc_gain_wiper)
  );

  // DAC pots are gain only; no offset pot exists
  pot_serial_model u_dac_pots (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr      (st_r.dac_wr),
    .sdata   (st_r.dac_port[CAL_DATA_BIT]),
    .sclk    (st_r.dac_port[CAL_CLK_BIT]),
    .clr     (pot_clr),
    .wiper0  (dac0_gain_wiper),
    .wiper1  (dac1_gain_wiper)
  );

  // Spacing guard between memory accesses; informs the host only
  hold_timer #(
    .W     (GAP_CNT_W),
    .COUNT (GAP_CYCLES)
  ) u_gap_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (nvm_access),
    .active  (),
    .idle    (gap_w)
  );

  // Memory busy window after its terminating write
  hold_timer #(
    .W     (BUSY_CNT_W),
    .COUNT (BUSY_CNT)
  ) u_busy_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (nvm_end_write),
    .active  (busy_w),
    .idle    ()
  );

  // Outputs straight from registers; hresp is tied to zero
  assign hrdata              = st_r.rdata;
  assign hreadyout           = st_r.ready;
  assign hresp               = 1'b0;
  assign adc_cal_sclk        = st_r.adc_port[CAL_CLK_BIT];
  assign adc_cal_sdata       = st_r.adc_port[CAL_DATA_BIT];
  assign dac_cal_sclk        = st_r.dac_port[CAL_CLK_BIT];
  assign dac_cal_sdata       = st_r.dac_port[CAL_DATA_BIT];
  assign adc_queue_clear     = st_r.clr[CLR_QUEUE_BIT];
  assign cal_pot_clear       = st_r.clr[CLR_POT_BIT];
  assign parallel_port_clear = st_r.clr[CLR_PARALLEL_BIT];
  assign analog_out_zero     = st_r.clr[CLR_DAC_BIT];
  assign global_clear        = st_r.clr[CLR_GLOBAL_BIT];
  assign nvm_busy            = busy_w;
  assign nvm_gap_ok          = gap_w;

endmodule : cal_reset_regs

// *** tb/cal_reset_regs_chk.sv ***
// Concurrent checks on the calibration, reset and presence bank.
// Assumes hready is fed back from hreadyout (zero-wait slave).
`timescale 1ns/10ps
module cal_reset_regs_chk
  import cal_regs_pkg::*;
#(
  parameter int BUSY_CNT = 50
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        adc_cal_sclk,
  input wire logic        adc_cal_sdata,
  input wire logic        dac_cal_sclk,
  input wire logic        dac_cal_sdata,
  input wire logic        adc_queue_clear,
  input wire logic        cal_pot_clear,
  input wire logic        parallel_port_clear,
  input wire logic        analog_out_zero,
  input wire logic        global_clear,
  input wire logic [7:0]  adc_offset_wiper,
  input wire logic [7:0]  adc_gain_wiper,
  input wire logic [7:0]  dac0_gain_wiper,
  input wire logic [7:0]  dac1_gain_wiper,
  input wire logic        nvm_end_write,
  input wire logic        nvm_busy
);
  logic       dp_v_r;
  logic       dp_wr_r;
  logic [7:0] dp_idx_r;
  logic       wr_adc;
  logic       wr_dac;
  logic       wr_rst;
  logic [4:0] clrs;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Address phase kept so the data phase can be judged; misaligned is a miss
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dp_v_r   <= 1'b0;
      dp_wr_r  <= 1'b0;
      dp_idx_r <= 8'h00;
    end else begin
      dp_v_r   <= hsel && hready && htrans == HTRANS_NONSEQ && haddr[31:10] == 22'h0
                  && haddr[1:0] == 2'h0;
      dp_wr_r  <= hwrite;
      dp_idx_r <= haddr[9:2];
    end
  end
  // Data-phase decodes
  assign wr_adc = dp_v_r && dp_wr_r && dp_idx_r == ADC_CAL_IDX;
  assign wr_dac = dp_v_r && dp_wr_r && dp_idx_r == DAC_CAL_IDX;
  assign wr_rst = dp_v_r && dp_wr_r && dp_idx_r == RESET_IDX;
  assign clrs = {global_clear, analog_out_zero, parallel_port_clear, cal_pot_clear,
                 adc_queue_clear};

  a_adc_follow: assert property (wr_adc |=>
    adc_cal_sclk == $past(hwdata[0]) && adc_cal_sdata == $past(hwdata[7]))
    else $error("adc port lines differ from written byte");
  a_dac_follow: assert property (wr_dac |=>
    dac_cal_sclk == $past(hwdata[0]) && dac_cal_sdata == $past(hwdata[7]))
    else $error("dac port lines differ from written byte");
  a_reset_map: assert property (wr_rst |=>
    clrs == ({5{$past(hwdata[4])}} | $past(hwdata[4:0])))
    else $error("clear pulses do not match written bits");
  a_clear_cause: assert property ((|clrs) |-> $past(wr_rst))
    else $error("clear pulse without a subsystem_reset_pulse write");
  a_presence_read: assert property (
    dp_v_r && !dp_wr_r && dp_idx_r == PRESENCE_IDX |-> hrdata == PRESENCE_VALUE)
    else $error("presence register read wrong");
  a_wo_zero: assert property (
    dp_v_r && !dp_wr_r && dp_idx_r inside {[8'h19:8'h1e]} |-> hrdata == 32'h0)
    else $error("write-only or unused place read nonzero");
  a_pot_reset: assert property (cal_pot_clear |=>
    {adc_offset_wiper, adc_gain_wiper, dac0_gain_wiper, dac1_gain_wiper} == {4{WIPER_RESET}})
    else $error("pots not returned to reset setting");
  a_wiper_cause: assert property (
    !$stable({adc_offset_wiper, adc_gain_wiper}) |-> $past(cal_pot_clear) || $past(wr_adc, 2))
    else $error("adc wiper moved without a frame end or clear");
  a_busy_hold: assert property (nvm_end_write |=> nvm_busy [*8])
    else $error("memory busy not held after end write");
endmodule : cal_reset_regs_chk

bind cal_reset_regs cal_reset_regs_chk #(.BUSY_CNT(BUSY_CNT)) u_chk (.*);

// *** tb/cal_pot_ref.sv ***
// Reference pair of serial calibration pots fed by host port writes.
// Assumes one wr pulse per port write with the written byte alongside.
`timescale 1ns/10ps
module cal_pot_ref (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic [7:0] wbyte,
  input  wire logic       clr,
  output logic [7:0]      wiper0,
  output logic [7:0]      wiper1
);
  logic       armed_r;
  logic [4:0] cnt_r;
  logic [9:0] shift_r;
  // Enable arms, clocked bits shift in MSB first, end byte loads if count is exact
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {armed_r, cnt_r, shift_r, wiper0, wiper1} <= {16'h0, 8'h80, 8'h80};
    end else if (clr) begin
      {armed_r, cnt_r, wiper0, wiper1} <= {6'h0, 8'h80, 8'h80};
    end else if (wr && wbyte == 8'h80) begin
      armed_r <= 1'b1;
      cnt_r   <= 5'h00;
    end else if (wr && wbyte[0]) begin
      shift_r <= {shift_r[8:0], wbyte[7]};
      cnt_r   <= cnt_r + 5'h01;
    end else if (wr && wbyte == 8'h00) begin
      armed_r <= 1'b0;
      // Only two pots: addresses 2 and 3 fall on nothing
      if (armed_r && cnt_r == 5'h0a) begin
        if (shift_r[9:8] == 2'h0) wiper0 <= shift_r[7:0];
        if (shift_r[9:8] == 2'h1) wiper1 <= shift_r[7:0];
      end
    end
  end
endmodule : cal_pot_ref

// *** tb/cal_reset_regs_tb_top.sv ***
// Self-checking bench for the calibration, reset and presence register bank.
// Assumes a zero-wait AHB-Lite slave; busy count shortened to keep the run brief.
`timescale 1ns/10ps
module cal_reset_regs_tb_top import cal_regs_pkg::*;;
  localparam int          BUSY_T = 50;
  localparam logic [31:0] A_ADC  = {22'h0, ADC_CAL_IDX, 2'h0};
  localparam logic [31:0] A_RST  = {22'h0, RESET_IDX, 2'h0};
  localparam logic [31:0] A_PRES = {22'h0, PRESENCE_IDX, 2'h0};
  localparam logic [31:0] A_STAT = {22'h0, STATUS_IDX, 2'h0};
  localparam logic [31:0] A_WIP  = {22'h0, WIPER_IDX, 2'h0};
  logic        ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, m_wr = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, nvm_access = 1'b0, nvm_end_write = 1'b0, nvm_busy, nvm_gap_ok;
  logic        adc_cal_sclk, adc_cal_sdata, dac_cal_sclk, dac_cal_sdata, m_clr = 1'b0;
  logic        adc_queue_clear, cal_pot_clear, parallel_port_clear, analog_out_zero, global_clear;
  logic [7:0]  adc_offset_wiper, adc_gain_wiper, dac0_gain_wiper, dac1_gain_wiper, m_byte = 8'h0;
  logic [7:0]  mw0 [2];
  logic [7:0]  mw1 [2];
  logic [7:0]  exp_w [4] = '{default: 8'h80};
  logic [4:0]  clrs;
  logic [3:0]  ports;
  int          num_errors = 0, total_checks = 0;

  assign hready = hreadyout;
  assign clrs   = {global_clear, analog_out_zero, parallel_port_clear, cal_pot_clear,
                   adc_queue_clear};
  assign ports  = {adc_cal_sclk, adc_cal_sdata, dac_cal_sclk, dac_cal_sdata};
  cal_reset_regs #(.BUSY_CNT(BUSY_T)) dut (.*);
  // One reference pot pair per calibration port
  cal_pot_ref u_ref_adc (.ref_clk(ref_clk), .rst(rst), .wr(m_wr[0]), .wbyte(m_byte), .clr(m_clr),
                         .wiper0(mw0[0]), .wiper1(mw1[0]));
  cal_pot_ref u_ref_dac (.ref_clk(ref_clk), .rst(rst), .wr(m_wr[1]), .wbyte(m_byte), .clr(m_clr),
                         .wiper0(mw0[1]), .wiper1(mw1[1]));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Bounded wait for an edge with hready high; a hang ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) begin
      num_errors++;
      close_out();
    end
  endtask : wait_ready
  // Single word transfer; entered and left right after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr32
  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(name, exp, rd);
  endtask : rd_chk
  task automatic cal_wr(input int p, input logic [7:0] b);
    wr32(A_ADC + 32'(p * 4), {24'h0, b});
    m_byte  <= b;
    m_wr[p] <= 1'b1;
    @(posedge ref_clk);
    m_wr    <= 2'h0;
  endtask : cal_wr
  task automatic pot_load(input int p, input logic [1:0] a, input logic [7:0] v, input int nb);
    logic [9:0] f;
    f = {a, v};
    cal_wr(p, 8'h80);
    for (int i = 9; i > 9 - nb; i--) cal_wr(p, {f[i], 7'h01});
    cal_wr(p, 8'h00);
  endtask : pot_load
  task automatic wipers_chk;
    repeat (3) @(posedge ref_clk);
    rd_chk("wiper_reg", A_WIP, {exp_w[3], exp_w[2], exp_w[1], exp_w[0]});
    chk("ref_adc", {mw1[0], mw0[0]}, {adc_gain_wiper, adc_offset_wiper});
    chk("ref_dac", {mw1[1], mw0[1]}, {dac1_gain_wiper, dac0_gain_wiper});
  endtask : wipers_chk
  // One subsystem_reset_pulse write; pulses land the cycle after the data phase
  task automatic rst_pulse(input logic [4:0] v);
    wr32(A_RST, {27'h0, v});
    m_clr <= v[1] | v[4];
    if (v[1] | v[4]) exp_w = '{default: 8'h80};
    #1;
    chk("clear_pulse", {27'h0, v[4] ? 5'h1f : v}, {27'h0, clrs});
    @(posedge ref_clk);
    m_clr <= 1'b0;
    #1;
    chk("clear_after", 32'h0, {27'h0, clrs});
    @(posedge ref_clk);
  endtask : rst_pulse

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk("presence", A_PRES, 32'h1);
    wr32(A_PRES, 32'hff);
    rd_chk("presence_ro", A_PRES, 32'h1);
    wr32(32'h400, 32'h81);
    rd_chk("unmapped", 32'h400, 32'h0);
    for (int i = 0; i < 6; i++) rd_chk("wo_read", A_ADC + 32'(i * 4), 32'h0);
    wipers_chk();
    // Load all four pots, then an address-2 frame and a short 9-bit frame that must be dropped
    pot_load(0, 2'h1, 8'h4f, 10);
    pot_load(0, 2'h0, 8'hff, 10);
    pot_load(1, 2'h0, 8'h00, 10);
    pot_load(1, 2'h1, 8'h4f, 10);
    pot_load(1, 2'h2, 8'h11, 10);
    pot_load(0, 2'h1, 8'h33, 9);
    exp_w = '{8'hff, 8'h4f, 8'h00, 8'h4f};
    wipers_chk();
    chk("ports_idle", 32'h0, {28'h0, ports});
    cal_wr(0, 8'h81);
    cal_wr(1, 8'h01);
    chk("ports_set", 32'he, {28'h0, ports});
    rst_pulse(5'h00);
    for (int i = 0; i < 5; i++) begin
      rst_pulse(5'h01 << i);
    end
    chk("ports_clr", 32'h0, {28'h0, ports});
    wipers_chk();
    nvm_end_write <= 1'b1;
    nvm_access    <= 1'b1;
    @(posedge ref_clk);
    nvm_end_write <= 1'b0;
    nvm_access    <= 1'b0;
    rd_chk("status_busy", A_STAT, 32'h1);
    chk("busy_pin", 32'h1, {31'h0, nvm_busy});
    chk("gap_pin", 32'h0, {31'h0, nvm_gap_ok});
    repeat (170) @(posedge ref_clk);
    rd_chk("status_free", A_STAT, 32'h2);
    chk("busy_pin_end", 32'h0, {31'h0, nvm_busy});
    chk("gap_pin_end", 32'h1, {31'h0, nvm_gap_ok});
    close_out();
  end
endmodule : cal_reset_regs_tb_top
